/* common/pin_map_pkg.sv */
package pin_map_pkg;
	// ----------------------------------------------------------------
	// Geometry
	// ----------------------------------------------------------------
	localparam int FIELD_W     = 6;
	localparam int FIRST_PIN   = 18;
	localparam int NUM_PINS    = 14;
	localparam int NUM_FUNCS   = 64;
	localparam int NUM_REGS    = 8;
	localparam int IDX_W       = 3;
	localparam int REG_W       = 16;
	localparam int PIN31_FIELD = 13;
	localparam int FULL_PKG    = 100;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [IDX_W-1:0] IDX_PINS_18_19 = 3'h0;
	localparam logic [IDX_W-1:0] IDX_PINS_30_31 = 3'h6;
	localparam logic [IDX_W-1:0] IDX_ALT_CLOCK  = 3'h7;

	// ----------------------------------------------------------------
	// Field layout and reset values
	// ----------------------------------------------------------------
	localparam int LO_FIELD_LSB  = 0;
	localparam int HI_FIELD_LSB  = 8;
	localparam int ALT_BIT_POS   = 0;
	localparam int LO_STRB       = 0;
	localparam int HI_STRB       = 1;
	localparam logic [FIELD_W-1:0] FIELD_RESET = 6'h00;
	localparam logic               ALT_RESET   = 1'h0;
	localparam logic [FIELD_W-1:0] FUNC_NONE   = 6'h00;

	// ----------------------------------------------------------------
	// Bus answers
	// ----------------------------------------------------------------
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	localparam logic [31:0] READ_ZERO   = 32'h0000_0000;

	typedef logic [FIELD_W-1:0] func_num_t;
	typedef enum logic {WR_COLLECT, WR_RESP} wr_state_t;
	typedef enum logic {RD_IDLE, RD_RESP} rd_state_t;
endpackage : pin_map_pkg

/* common/map_cfg_if.sv */
`timescale 1ns/1ns
interface map_cfg_if;
	// ----------------------------------------------------------------
	// Mapping state and peripheral outputs to the routing logic
	// ----------------------------------------------------------------
	pin_map_pkg::func_num_t                         field [pin_map_pkg::NUM_PINS];
	logic                                           alt_bit;
	logic [pin_map_pkg::NUM_FUNCS-1:0]              fn_out;
	logic                                           sck_out;

	modport src (output field, output alt_bit, output fn_out, output sck_out);
	modport dst (input field, input alt_bit, input fn_out, input sck_out);
endinterface : map_cfg_if

/* hw/pin_route_mux.sv */
`timescale 1ns/1ns
module pin_route_mux #(
	parameter pin_map_pkg::func_num_t SCK_FUNC = 6'h08
) (
	// Clock and reset
	input  wire logic                              clk,
	input  wire logic                              rstn,
	// Mapping state
	map_cfg_if.dst                                 cfg,
	// Remappable pins
	output      logic [pin_map_pkg::NUM_PINS-1:0]  pin_out,
	output      logic [pin_map_pkg::NUM_PINS-1:0]  pin_drive_n
);
	logic [pin_map_pkg::NUM_PINS-1:0] sel_lvl;
	logic [pin_map_pkg::NUM_PINS-1:0] sel_on;

	// ----------------------------------------------------------------
	// Per-pin function select
	// ----------------------------------------------------------------
	for (genvar p = 0; p < pin_map_pkg::NUM_PINS; p++) begin : g_pin
		wire logic is_sck = (cfg.field[p] == SCK_FUNC);
		// Clock taken off the remappable pins while alternate routing
		wire logic blocked = is_sck && cfg.alt_bit;
		// Number zero is no function: pin left undriven
		assign sel_on[p]  = (cfg.field[p] != pin_map_pkg::FUNC_NONE)
				&& !blocked;
		assign sel_lvl[p] = is_sck ? cfg.sck_out
				: cfg.fn_out[cfg.field[p]];
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pin_out     <= '0;
			pin_drive_n <= '1;
		end else begin
			pin_out     <= sel_lvl & sel_on;
			pin_drive_n <= ~sel_on;
		end
	end
endmodule : pin_route_mux

/* hw/alt_clock_steer.sv */
`timescale 1ns/1ns
module alt_clock_steer (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rstn,
	// Mapping state
	map_cfg_if.dst    cfg,
	// Dedicated alternate clock pin
	output      logic dedicated_alt_clock_pin,
	output      logic dedicated_alt_clock_drive_n
);
	// ----------------------------------------------------------------
	// Dedicated pin carries the clock only while alternate routing
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			dedicated_alt_clock_pin     <= 1'b0;
			dedicated_alt_clock_drive_n <= 1'b1;
		end else begin
			dedicated_alt_clock_pin     <= cfg.alt_bit & cfg.sck_out;
			dedicated_alt_clock_drive_n <= ~cfg.alt_bit;
		end
	end
endmodule : alt_clock_steer

/* hw/remap_output_pin_select.sv */
`timescale 1ns/1ns
module remap_output_pin_select #(
	parameter int                     PIN_COUNT = 100,
	parameter pin_map_pkg::func_num_t SCK_FUNC  = 6'h08
) (
	// Clock and reset
	input  wire logic                                clk,
	input  wire logic                                rstn,
	// AXI4-Lite write address
	input  wire logic [31:0]                         s_axi_awaddr,
	input  wire logic [2:0]                          s_axi_awprot,
	input  wire logic                                s_axi_awvalid,
	output      logic                                s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0]                         s_axi_wdata,
	input  wire logic [3:0]                          s_axi_wstrb,
	input  wire logic                                s_axi_wvalid,
	output      logic                                s_axi_wready,
	// AXI4-Lite write response
	output      logic [1:0]                          s_axi_bresp,
	output      logic                                s_axi_bvalid,
	input  wire logic                                s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [31:0]                         s_axi_araddr,
	input  wire logic [2:0]                          s_axi_arprot,
	input  wire logic                                s_axi_arvalid,
	output      logic                                s_axi_arready,
	// AXI4-Lite read data
	output      logic [31:0]                         s_axi_rdata,
	output      logic [1:0]                          s_axi_rresp,
	output      logic                                s_axi_rvalid,
	input  wire logic                                s_axi_rready,
	// Peripheral output functions
	input  wire logic [pin_map_pkg::NUM_FUNCS-1:0]   periph_fn_out,
	input  wire logic                                serial_port1_clock_out,
	// Remappable pins 18 to 31
	output      logic [pin_map_pkg::NUM_PINS-1:0]    remappable_pin,
	output      logic [pin_map_pkg::NUM_PINS-1:0]    remappable_pin_drive_n,
	// Dedicated alternate clock pin
	output      logic                                dedicated_alt_clock_pin,
	output      logic                                dedicated_alt_clock_drive_n
);
	localparam logic HAS_PIN31 = (PIN_COUNT >= pin_map_pkg::FULL_PKG);

	// ----------------------------------------------------------------
	// Address decode helpers
	// ----------------------------------------------------------------
	function automatic logic addr_hit(input logic [31:0] addr);
		addr_hit = (addr[31:5] == 27'h0) && (addr[1:0] == 2'h0);
	endfunction : addr_hit

	function automatic logic [pin_map_pkg::IDX_W-1:0] addr_idx(
		input logic [31:0] addr);
		addr_idx = addr[4:2];
	endfunction : addr_idx

	// Byte-lane merge of one six-bit field
	function automatic pin_map_pkg::func_num_t merge_field(
		input pin_map_pkg::func_num_t old_val,
		input logic [31:0]            data,
		input logic [3:0]             strb,
		input int                     lsb,
		input int                     lane);
		merge_field = strb[lane]
			? data[lsb +: pin_map_pkg::FIELD_W] : old_val;
	endfunction : merge_field

	// Readback of a pair register, unimplemented bits as zero
	function automatic logic [31:0] pair_word(
		input pin_map_pkg::func_num_t lo,
		input pin_map_pkg::func_num_t hi);
		logic [31:0] w;
		w = pin_map_pkg::READ_ZERO;
		w[pin_map_pkg::LO_FIELD_LSB +: pin_map_pkg::FIELD_W] = lo;
		w[pin_map_pkg::HI_FIELD_LSB +: pin_map_pkg::FIELD_W] = hi;
		pair_word = w;
	endfunction : pair_word

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	pin_map_pkg::wr_state_t  wr_state_r;
	pin_map_pkg::wr_state_t  wr_state_nxt;
	pin_map_pkg::rd_state_t  rd_state_r;
	pin_map_pkg::rd_state_t  rd_state_nxt;
	logic                    aw_have_r;
	logic                    w_have_r;
	logic [31:0]             aw_addr_r;
	logic [31:0]             w_data_r;
	logic [3:0]              w_strb_r;
	logic [1:0]              bresp_r;
	logic [31:0]             rdata_r;
	logic [1:0]              rresp_r;
	pin_map_pkg::func_num_t  field_r   [pin_map_pkg::NUM_PINS];
	pin_map_pkg::func_num_t  field_nxt [pin_map_pkg::NUM_PINS];
	logic                    alt_r;
	logic                    alt_nxt;

	// ----------------------------------------------------------------
	// Write channel
	// ----------------------------------------------------------------
	wire logic aw_take = s_axi_awvalid && s_axi_awready;
	wire logic w_take  = s_axi_wvalid && s_axi_wready;
	wire logic do_write = (wr_state_r == pin_map_pkg::WR_COLLECT)
			&& aw_have_r && w_have_r;
	wire logic wr_hit = addr_hit(aw_addr_r);
	wire logic [pin_map_pkg::IDX_W-1:0] wr_idx = addr_idx(aw_addr_r);
	wire logic b_done = s_axi_bvalid && s_axi_bready;

	assign s_axi_awready = (wr_state_r == pin_map_pkg::WR_COLLECT)
			&& !aw_have_r;
	assign s_axi_wready  = (wr_state_r == pin_map_pkg::WR_COLLECT)
			&& !w_have_r;
	assign s_axi_bvalid  = (wr_state_r == pin_map_pkg::WR_RESP);
	assign s_axi_bresp   = bresp_r;

	always_comb begin
		wr_state_nxt = wr_state_r;
		unique case (wr_state_r)
			pin_map_pkg::WR_COLLECT: begin
				if (do_write) begin
					wr_state_nxt = pin_map_pkg::WR_RESP;
				end
			end
			pin_map_pkg::WR_RESP: begin
				if (b_done) begin
					wr_state_nxt = pin_map_pkg::WR_COLLECT;
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wr_state_r <= pin_map_pkg::WR_COLLECT;
			aw_have_r  <= 1'b0;
			w_have_r   <= 1'b0;
			aw_addr_r  <= '0;
			w_data_r   <= '0;
			w_strb_r   <= '0;
			bresp_r    <= pin_map_pkg::RESP_OKAY;
		end else begin
			wr_state_r <= wr_state_nxt;
			if (aw_take) begin
				aw_have_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end else if (do_write) begin
				aw_have_r <= 1'b0;
			end
			if (w_take) begin
				w_have_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end else if (do_write) begin
				w_have_r <= 1'b0;
			end
			if (do_write) begin
				bresp_r <= wr_hit ? pin_map_pkg::RESP_OKAY
						: pin_map_pkg::RESP_SLVERR;
			end
		end
	end

	// ----------------------------------------------------------------
	// Mapping registers
	// ----------------------------------------------------------------
	always_comb begin
		for (int p = 0; p < pin_map_pkg::NUM_PINS; p++) begin
			field_nxt[p] = field_r[p];
		end
		alt_nxt = alt_r;
		if (do_write && wr_hit) begin
			for (int r = 0; r < pin_map_pkg::NUM_PINS / 2; r++) begin
				if (wr_idx == 3'(r)) begin
					field_nxt[2*r] = merge_field(field_r[2*r],
						w_data_r, w_strb_r,
						pin_map_pkg::LO_FIELD_LSB,
						pin_map_pkg::LO_STRB);
					field_nxt[2*r+1] = merge_field(field_r[2*r+1],
						w_data_r, w_strb_r,
						pin_map_pkg::HI_FIELD_LSB,
						pin_map_pkg::HI_STRB);
				end
			end
			if (wr_idx == pin_map_pkg::IDX_ALT_CLOCK
					&& w_strb_r[pin_map_pkg::LO_STRB]) begin
				alt_nxt = w_data_r[pin_map_pkg::ALT_BIT_POS];
			end
		end
		if (!HAS_PIN31) begin
			field_nxt[pin_map_pkg::PIN31_FIELD] =
				pin_map_pkg::FIELD_RESET;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int p = 0; p < pin_map_pkg::NUM_PINS; p++) begin
				field_r[p] <= pin_map_pkg::FIELD_RESET;
			end
			alt_r <= pin_map_pkg::ALT_RESET;
		end else begin
			for (int p = 0; p < pin_map_pkg::NUM_PINS; p++) begin
				field_r[p] <= field_nxt[p];
			end
			alt_r <= alt_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Read channel
	// ----------------------------------------------------------------
	wire logic ar_take = s_axi_arvalid && s_axi_arready;
	wire logic r_done  = s_axi_rvalid && s_axi_rready;
	wire logic rd_hit  = addr_hit(s_axi_araddr);
	wire logic [pin_map_pkg::IDX_W-1:0] rd_idx = addr_idx(s_axi_araddr);
	logic [31:0] rd_word;

	assign s_axi_arready = (rd_state_r == pin_map_pkg::RD_IDLE);
	assign s_axi_rvalid  = (rd_state_r == pin_map_pkg::RD_RESP);
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;

	always_comb begin
		rd_word = pin_map_pkg::READ_ZERO;
		for (int r = 0; r < pin_map_pkg::NUM_PINS / 2; r++) begin
			if (rd_idx == 3'(r)) begin
				rd_word = pair_word(field_r[2*r], field_r[2*r+1]);
			end
		end
		if (rd_idx == pin_map_pkg::IDX_ALT_CLOCK) begin
			rd_word[pin_map_pkg::ALT_BIT_POS] = alt_r;
		end
	end

	always_comb begin
		rd_state_nxt = rd_state_r;
		unique case (rd_state_r)
			pin_map_pkg::RD_IDLE: begin
				if (ar_take) begin
					rd_state_nxt = pin_map_pkg::RD_RESP;
				end
			end
			pin_map_pkg::RD_RESP: begin
				if (r_done) begin
					rd_state_nxt = pin_map_pkg::RD_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rd_state_r <= pin_map_pkg::RD_IDLE;
			rdata_r    <= pin_map_pkg::READ_ZERO;
			rresp_r    <= pin_map_pkg::RESP_OKAY;
		end else begin
			rd_state_r <= rd_state_nxt;
			if (ar_take) begin
				rdata_r <= rd_hit ? rd_word : pin_map_pkg::READ_ZERO;
				rresp_r <= rd_hit ? pin_map_pkg::RESP_OKAY
						: pin_map_pkg::RESP_SLVERR;
			end
		end
	end

	// ----------------------------------------------------------------
	// Routing
	// ----------------------------------------------------------------
	map_cfg_if cfg ();

	for (genvar p = 0; p < pin_map_pkg::NUM_PINS; p++) begin : g_cfg
		assign cfg.field[p] = field_r[p];
	end
	assign cfg.alt_bit = alt_r;
	assign cfg.fn_out  = periph_fn_out;
	assign cfg.sck_out = serial_port1_clock_out;

	pin_route_mux #(
		.SCK_FUNC (SCK_FUNC)
	) u_pin_route_mux (
		.clk         (clk),
		.rstn        (rstn),
		.cfg         (cfg.dst),
		.pin_out     (remappable_pin),
		.pin_drive_n (remappable_pin_drive_n)
	);

	alt_clock_steer u_alt_clock_steer (
		.clk                         (clk),
		.rstn                        (rstn),
		.cfg                         (cfg.dst),
		.dedicated_alt_clock_pin     (dedicated_alt_clock_pin),
		.dedicated_alt_clock_drive_n (dedicated_alt_clock_drive_n)
	);
endmodule : remap_output_pin_select

/* verif/periph_model.sv */
`timescale 1ns/1ns
module periph_model (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// Peripheral function outputs
	output      logic [63:0] fn_out,
	output      logic        sck_out
);
	// ----------------------------------------------------------------
	// Free-running outputs, new pattern every cycle
	// ----------------------------------------------------------------
	logic [63:0] state_r;
	logic [63:0] state_nxt;

	assign state_nxt = state_r ^ (state_r << 7) ^ (state_r >> 9);
	assign fn_out    = {state_r[63:1], 1'b0};
	assign sck_out   = state_r[0] ^ state_r[40];

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_r <= 64'h5a3c_96e1_0f72_b4d8;
		end else begin
			state_r <= state_nxt;
		end
	end
endmodule : periph_model

/* verif/pin_select_monitor.sv */
`timescale 1ns/1ns
module pin_select_monitor #(
	parameter int PIN_COUNT = 100
) (
	// Clock and reset
	input wire logic                             clk,
	input wire logic                             rstn,
	// Register bus
	input wire logic                             s_axi_awvalid,
	input wire logic                             s_axi_awready,
	input wire logic                             s_axi_wvalid,
	input wire logic                             s_axi_wready,
	input wire logic                             s_axi_bvalid,
	input wire logic [31:0]                      s_axi_araddr,
	input wire logic                             s_axi_arvalid,
	input wire logic                             s_axi_arready,
	input wire logic [31:0]                      s_axi_rdata,
	input wire logic [1:0]                       s_axi_rresp,
	input wire logic                             s_axi_rvalid,
	// Pins
	input wire logic                             serial_port1_clock_out,
	input wire logic [pin_map_pkg::NUM_PINS-1:0] remappable_pin,
	input wire logic [pin_map_pkg::NUM_PINS-1:0] remappable_pin_drive_n,
	input wire logic                             dedicated_alt_clock_pin,
	input wire logic                             dedicated_alt_clock_drive_n
);
	// ----------------------------------------------------------------
	// Bus and pin checks
	// ----------------------------------------------------------------
	wire ar_take = s_axi_arvalid && s_axi_arready;
	wire ar_bad  = s_axi_araddr[31:5] != 27'h0 || s_axi_araddr[1:0] != 2'h0;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_resp_next;
		!s_axi_bvalid ##1 s_axi_bvalid;
	endsequence

	a_write_resp: assert property (s_wr_taken |=> s_resp_next)
		else $error("write answer late");
	a_read_answer: assert property (ar_take |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer missing");
	a_reserved_zero: assert property (
		s_axi_rvalid |-> (s_axi_rdata & 32'hffff_c0c0) == 32'h0)
		else $error("reserved bits not zero");
	a_alt_upper_zero: assert property (
		ar_take && s_axi_araddr == 32'h1c |=> s_axi_rdata[31:1] == 31'h0)
		else $error("alternate register upper bits set");
	a_pin31_absent: assert property (
		ar_take && s_axi_araddr == 32'h18 && PIN_COUNT < 100
		|=> s_axi_rdata[13:8] == 6'h0)
		else $error("absent field not zero");
	a_bad_addr: assert property (ar_take && ar_bad
		|=> s_axi_rresp == pin_map_pkg::RESP_SLVERR
		&& s_axi_rdata == pin_map_pkg::READ_ZERO)
		else $error("unmapped read not refused");
	a_alt_follows: assert property (
		!dedicated_alt_clock_drive_n
		|-> dedicated_alt_clock_pin == $past(serial_port1_clock_out))
		else $error("alternate pin does not follow clock");
	a_idle_low: assert property (
		(remappable_pin & remappable_pin_drive_n) == '0
		&& (!dedicated_alt_clock_drive_n || !dedicated_alt_clock_pin))
		else $error("undriven pin not low");
	a_reset_state: assert property ($rose(rstn)
		|-> &remappable_pin_drive_n && dedicated_alt_clock_drive_n)
		else $error("pins driven after reset");
endmodule : pin_select_monitor

/* verif/tb_remap_output_pin_select.sv */
`timescale 1ns/1ns
module tb_remap_output_pin_select;
	localparam logic [5:0] SCK = 6'h08;
	logic        clk;
	logic        rstn = 1'b0;
	logic [31:0] awaddr = 32'h0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] araddr = 32'h0;
	logic [3:0]  wstrb = 4'h0;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic [1:0]  awready, wready, bvalid, arready, rvalid, apin, apin_dn;
	logic [1:0]  bresp [2];
	logic [1:0]  rresp [2];
	logic [31:0] rdata [2];
	logic [13:0] pin [2];
	logic [13:0] pin_dn [2];
	logic [63:0] fn, fn_q;
	logic        sck, sck_q;
	logic [15:0] mdl [8];
	logic [31:0] seed = 32'h0000a99e;
	int          fails = 0;
	int          num_checks = 0;

	// ----------------------------------------------------------------
	// Design pair: full package and one without the last field
	// ----------------------------------------------------------------
	for (genvar g = 0; g < 2; g++) begin : g_dut
		remap_output_pin_select #(.PIN_COUNT(g ? 80 : 100), .SCK_FUNC(SCK))
		remap_output_pin_select_inst (
			.clk(clk), .rstn(rstn), .s_axi_awaddr(awaddr),
			.s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
			.s_axi_awready(awready[g]), .s_axi_wdata(wdata),
			.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready[g]),
			.s_axi_bresp(bresp[g]), .s_axi_bvalid(bvalid[g]),
			.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
			.s_axi_arvalid(arvalid), .s_axi_arready(arready[g]),
			.s_axi_rdata(rdata[g]), .s_axi_rresp(rresp[g]),
			.s_axi_rvalid(rvalid[g]), .s_axi_rready(rready),
			.periph_fn_out(fn), .serial_port1_clock_out(sck),
			.remappable_pin(pin[g]), .remappable_pin_drive_n(pin_dn[g]),
			.dedicated_alt_clock_pin(apin[g]),
			.dedicated_alt_clock_drive_n(apin_dn[g]));
	end
	periph_model periph_model_inst (.clk(clk), .rstn(rstn), .fn_out(fn),
		.sck_out(sck));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		fn_q <= fn;
		sck_q <= sck;
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic axi_wr(input logic [31:0] a, input logic [31:0] d,
		input logic [3:0] s);
		logic [1:0] e;
		int         n;
		e = (a[31:5] != 0 || a[1:0] != 0) ? 2'h2 : 2'h0;
		if (e == 2'h0 && a[4:2] == 3'h7) begin
			if (s[0]) mdl[7] = {15'h0, d[0]};
		end else if (e == 2'h0) begin
			if (s[0]) mdl[a[4:2]][7:0] = {2'h0, d[5:0]};
			if (s[1]) mdl[a[4:2]][15:8] = {2'h0, d[13:8]};
		end
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (!(awready[0] === 1'b1 && wready[0] === 1'b1) && n < 64);
		@(posedge clk);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		while (bvalid[0] !== 1'b1 && n < 64) begin
			@(negedge clk);
			n++;
		end
		chk({bvalid[0], bresp[0]}, {1'b1, e});
		chk({bvalid[1], bresp[1]}, {1'b1, e});
		@(posedge clk);
		bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [31:0] a);
		logic [31:0] e, e2;
		logic [1:0]  er;
		int          n;
		er = (a[31:5] != 0 || a[1:0] != 0) ? 2'h2 : 2'h0;
		e = (a[31:5] == 0 && a[1:0] == 0) ? {16'h0, mdl[a[4:2]]} : 32'h0;
		e2 = (a == 32'h18) ? {e[31:14], 6'h0, e[7:0]} : e;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (arready[0] !== 1'b1 && n < 64);
		@(posedge clk);
		arvalid <= 1'b0;
		do @(negedge clk); while (rvalid[0] !== 1'b1 && n++ < 64);
		chk({rvalid[0], rresp[0], rdata[0]}, {1'b1, er, e});
		chk({rvalid[1], rresp[1], rdata[1]}, {1'b1, er, e2});
		@(posedge clk);
		rready <= 1'b0;
	endtask : axi_rd

	task automatic chk_pins();
		logic [13:0] lv, dn;
		logic [5:0]  f;
		repeat (3) begin
			@(negedge clk);
			for (int k = 0; k < 14; k++) begin
				f = k[0] ? mdl[k/2][13:8] : mdl[k/2][5:0];
				dn[k] = f == 6'h0 || (mdl[7][0] && f == SCK);
				lv[k] = dn[k] ? 1'b0 : (f == SCK ? sck_q : fn_q[f]);
			end
			chk({pin_dn[0], pin[0]}, {dn, lv});
			chk({apin_dn[0], apin[0]}, {!mdl[7][0], mdl[7][0] & sck_q});
			chk({pin_dn[1], pin[1]}, {dn | 14'h2000, lv & 14'h1fff});
			chk({apin_dn[1], apin[1]}, {!mdl[7][0], mdl[7][0] & sck_q});
		end
	endtask : chk_pins

	task automatic reset_check();
		rstn <= 1'b0;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		for (int i = 0; i < 8; i++) mdl[i] = 16'h0;
		for (int i = 0; i < 8; i++) axi_rd(i * 4);
		chk_pins();
		$display("reset test done");
	endtask : reset_check

	task automatic report_and_stop();
		$display("checks=%0d mismatches=%0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : report_and_stop

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] a;
		reset_check();
		for (int i = 0; i < 40; i++) begin
			seed = xs(seed);
			a = {27'h0, seed[4:2], 2'h0};
			if (seed[31:30] == 2'h3) a = a + 32'h21;
			axi_wr(a, xs(seed), seed[11:8]);
			axi_rd(a);
			chk_pins();
		end
		$display("random test done");
		axi_wr(32'h0, {18'h0, SCK, 2'h3, SCK}, 4'hf);
		axi_wr(32'h18, 32'hffff_ffff, 4'h2);
		axi_rd(32'h18);
		chk_pins();
		axi_wr(32'h1c, 32'hffff_ffff, 4'hf);
		axi_rd(32'h1c);
		chk_pins();
		axi_wr(32'h1c, 32'h0, 4'h1);
		chk_pins();
		$display("alternate clock test done");
		@(posedge clk);
		reset_check();
		report_and_stop();
	end

	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		report_and_stop();
	end
endmodule : tb_remap_output_pin_select

bind remap_output_pin_select pin_select_monitor #(.PIN_COUNT(PIN_COUNT))
	pin_select_monitor_inst (.clk(clk), .rstn(rstn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid),
	.serial_port1_clock_out(serial_port1_clock_out),
	.remappable_pin(remappable_pin),
	.remappable_pin_drive_n(remappable_pin_drive_n),
	.dedicated_alt_clock_pin(dedicated_alt_clock_pin),
	.dedicated_alt_clock_drive_n(dedicated_alt_clock_drive_n));
